// [common/uart_status_pkg.sv]
// Package: offsets, field positions, reset values and carrier types of the status block
package uart_status_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the register port
	// ----------------------------------------------------------------
	localparam logic [3:0] OFF_HOLDING = 4'h0;
	localparam logic [3:0] OFF_MODEM_CONTROL = 4'h4;
	localparam logic [3:0] OFF_LINE_STATUS = 4'h5;
	localparam logic [3:0] OFF_MODEM_STATUS = 4'h6;
	localparam logic [3:0] OFF_SCRATCH = 4'h7;
	localparam logic [3:0] OFF_TX_SPACE = 4'h8;
	localparam logic [3:0] OFF_RX_FILL = 4'h9;
	localparam logic [3:0] OFF_PIN_DIR = 4'hA;

	// ----------------------------------------------------------------
	// Modem control field positions
	// ----------------------------------------------------------------
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_ALT_SELECT = 2;
	localparam int MC_OUT2 = 3;
	localparam int MC_LOOPBACK = 4;
	localparam int MC_XON_ANY = 5;
	localparam int MC_IR_MODE = 6;
	localparam int MC_PRESCALE = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_MODEM_CONTROL = 8'h00;
	localparam logic [7:0] RST_SCRATCH = 8'hFF;
	localparam logic [7:0] RST_FLOW_THRESHOLD = 8'h00;
	localparam logic [7:0] RST_TRIGGER_LEVELS = 8'h00;
	localparam logic [7:0] RST_PIN_DIR = 8'h00;

	// ----------------------------------------------------------------
	// Queue geometry and timing
	// ----------------------------------------------------------------
	localparam int QUEUE_DEPTH = 64;
	localparam int COUNT_W = 7;
	localparam logic [COUNT_W-1:0] QUEUE_FULL_COUNT = 7'h40;
	localparam int LEVEL_SHIFT = 2;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;

	// Legacy trigger tables, indexed by the two-bit legacy field
	localparam logic [COUNT_W-1:0] LEGACY_TX_TRIG [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
	localparam logic [COUNT_W-1:0] LEGACY_RX_TRIG [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic breakSeen;
		logic frameErr;
		logic parityErr;
		logic [7:0] data;
	} rx_entry_type;

	localparam int RX_ENTRY_W = $bits(rx_entry_type);

	typedef struct packed {
		logic cdN;
		logic riN;
		logic dsrN;
		logic ctsN;
	} modem_in_type;

endpackage

// [logic/stream_fifo.sv]
// Parameterised valid/ready queue with fill count
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	// Fill level
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;
	logic push;
	logic pop;

	assign count = wrPtr_r - rdPtr_r;
	assign inReady = (count != DEPTH[AW:0]);
	assign outValid = (count != '0);
	assign outData = mem[rdPtr_r[AW-1:0]];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wrPtr_r <= '0;
		end else if (push) begin
			wrPtr_r <= wrPtr_r + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdPtr_r <= '0;
		end else if (pop) begin
			rdPtr_r <= rdPtr_r + 1'b1;
		end
	end

	// Storage has no reset; only pointers define content
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wrPtr_r[AW-1:0]] <= inData;
		end
	end
endmodule
`default_nettype wire

// [logic/uart_status_core.sv]
// Status, modem-input, queue and threshold logic of the serial port
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1: Prescale bit set divides baud clock by four; writable only with enhanced enable.
// RL2: Infrared mode bit enables infrared coding; writable only with enhanced enable.
// RL3: Data-ready reads 1 while any received character is queued.
// RL4: Character arriving on full receive queue sets overrun and is dropped.
// RL5: Parity error flag belongs to the head-of-queue character.
// RL6: Framing error flag belongs to the head-of-queue character.
// RL7: Break flagged on long low line; only one break character queued per break.
// RL8: Transmit-holding-empty is 1 exactly when the transmit queue is empty.
// RL9: Transmitter-idle is 1 only when queue and shift register are both empty.
// RL10: Error summary is 1 while any queued byte carries an error.
// RL11: Modem input changes set delta flags; request interrupt when enabled.
// RL12: Ring delta sets only on ring input rising, end of ringing.
// RL13: Upper status bits show inverted inputs, or control bits in loopback.
// RL14: Auto CTS stops transmission after current character while CTS# high.
// RL15: Scratch byte holds written data; resets to FF.
// RL16: Flow threshold replaces modem status when alternate select and enhanced enable.
// RL17: Receive count at or above halt level drops RTS or requests XOFF.
// RL18: Receive count at or below resume level raises RTS or requests XON.
// RL19: Transmit trigger is nibble times four, zero selects legacy field.
// RL20: Receive trigger is nibble times four, zero selects legacy field.
// RL21: Space counter reads free transmit entries; fill counter reads queued characters.
// RL22: Each direction bit sets its pin as output when 1.
// RL23: Trigger levels replace scratch byte under the same selection.
// RL24: Reading modem status clears deltas; concurrent changes stay flagged.
module uart_status_core
	import uart_status_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWData,
	output logic [7:0] regRData,
	// Settings held in neighbouring registers
	input wire logic enhancedEnable,
	input wire logic autoCtsEnable,
	input wire logic autoRtsEnable,
	input wire logic swFlowEnable,
	input wire logic modemIrqEnable,
	input wire logic [1:0] legacyTxTrig,
	input wire logic [1:0] legacyRxTrig,
	// Receiver side
	input wire logic rxInValid,
	input wire rx_entry_type rxIn,
	// Transmitter side
	output logic txOutValid,
	input wire logic txOutReady,
	output logic [7:0] txOutData,
	input wire logic txShiftBusy,
	// Modem pins
	input wire modem_in_type modemIn,
	output logic rtsN,
	output logic dtrN,
	// Flow requests to the transmitter
	output logic xoffRequest,
	output logic xonRequest,
	// Clocking and mode outputs
	output logic baudTick,
	output logic irEnable,
	output logic [7:0] pinDirection,
	// Interrupt requests
	output logic modemStatusReq,
	output logic txReadyReq,
	output logic rxReadyReq
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] modemControl_r;
	logic [7:0] scratchByte_r;
	logic [7:0] flowThreshold_r;
	logic [7:0] triggerLevels_r;
	logic [7:0] pinDirection_r;
	logic [7:0] regRData_r;
	logic [7:0] regRData_nxt;
	logic altSelect;
	logic wrEn;
	logic rdEn;

	assign altSelect = enhancedEnable && modemControl_r[MC_ALT_SELECT];
	assign wrEn = regWrite && !regRead;
	assign rdEn = regRead;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			modemControl_r <= RST_MODEM_CONTROL;
		end else if (wrEn && regAddr == OFF_MODEM_CONTROL) begin
			modemControl_r[4:0] <= regWData[4:0];
			if (enhancedEnable) begin
				modemControl_r[7:5] <= regWData[7:5]; // RL1 RL2
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scratchByte_r <= RST_SCRATCH; // RL15
			triggerLevels_r <= RST_TRIGGER_LEVELS;
		end else if (wrEn && regAddr == OFF_SCRATCH) begin
			if (altSelect) begin
				triggerLevels_r <= regWData; // RL23
			end else begin
				scratchByte_r <= regWData; // RL15
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			flowThreshold_r <= RST_FLOW_THRESHOLD;
		end else if (wrEn && regAddr == OFF_MODEM_STATUS && altSelect) begin
			flowThreshold_r <= regWData; // RL16
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pinDirection_r <= RST_PIN_DIR;
		end else if (wrEn && regAddr == OFF_PIN_DIR) begin
			pinDirection_r <= regWData;
		end
	end

	assign pinDirection = pinDirection_r; // RL22
	assign irEnable = modemControl_r[MC_IR_MODE]; // RL2

	// ----------------------------------------------------------------
	// Baud prescaler
	// ----------------------------------------------------------------
	logic [1:0] prescaleCnt_r;
	logic baudTick_r;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prescaleCnt_r <= 2'h0;
		end else begin
			prescaleCnt_r <= prescaleCnt_r + 2'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			baudTick_r <= 1'b0;
		end else begin
			baudTick_r <= !modemControl_r[MC_PRESCALE] || (prescaleCnt_r == PRESCALE_LAST); // RL1
		end
	end

	assign baudTick = baudTick_r;

	// ----------------------------------------------------------------
	// Receive queue
	// ----------------------------------------------------------------
	logic rxPushValid;
	logic rxPushReady;
	logic rxHeadValid;
	logic rxPop;
	rx_entry_type rxHead;
	logic [COUNT_W-1:0] rxCount;
	logic breakHeld_r;
	logic overrun_r;
	logic [COUNT_W-1:0] errCount_r;
	logic rxPushErr;
	logic rxPopErr;
	logic lineStatusRead;

	// A break lasting several frames yields one queued entry only
	assign rxPushValid = rxInValid && !(rxIn.breakSeen && breakHeld_r); // RL7
	assign rxPop = rdEn && regAddr == OFF_HOLDING && rxHeadValid;
	assign lineStatusRead = rdEn && regAddr == OFF_LINE_STATUS;

	stream_fifo #(
		.WIDTH(RX_ENTRY_W),
		.DEPTH(QUEUE_DEPTH)
	) rxQueue (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.inValid(rxPushValid),
		.inReady(rxPushReady),
		.inData(rxIn),
		.outValid(rxHeadValid),
		.outReady(rxPop),
		.outData(rxHead),
		.count(rxCount)
	);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			breakHeld_r <= 1'b0;
		end else if (rxInValid) begin
			breakHeld_r <= rxIn.breakSeen; // RL7
		end
	end

	// New overrun wins over the clearing read
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			overrun_r <= 1'b0;
		end else if (rxPushValid && !rxPushReady) begin
			overrun_r <= 1'b1; // RL4
		end else if (lineStatusRead) begin
			overrun_r <= 1'b0;
		end
	end

	assign rxPushErr = rxPushValid && rxPushReady && (rxIn.parityErr || rxIn.frameErr || rxIn.breakSeen);
	assign rxPopErr = rxPop && (rxHead.parityErr || rxHead.frameErr || rxHead.breakSeen);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			errCount_r <= '0;
		end else if (rxPushErr && !rxPopErr) begin
			errCount_r <= errCount_r + 7'h1; // RL10
		end else if (rxPopErr && !rxPushErr) begin
			errCount_r <= errCount_r - 7'h1; // RL10
		end
	end

	// ----------------------------------------------------------------
	// Transmit queue
	// ----------------------------------------------------------------
	logic txPush;
	logic txPushReady;
	logic txHeadValid;
	logic txCtsHold;
	logic [7:4] modemLevel_r;
	logic [COUNT_W-1:0] txCount;
	logic [COUNT_W-1:0] txSpace;

	// Held-off write to a full queue is dropped
	assign txPush = wrEn && regAddr == OFF_HOLDING;
	// Shifter finishes its character; only the next hand-over is held
	assign txCtsHold = autoCtsEnable && !modemLevel_r[4]; // RL14

	stream_fifo #(
		.WIDTH(8),
		.DEPTH(QUEUE_DEPTH)
	) txQueue (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.inValid(txPush),
		.inReady(txPushReady),
		.inData(regWData),
		.outValid(txHeadValid),
		.outReady(txOutReady && !txCtsHold),
		.outData(txOutData),
		.count(txCount)
	);

	assign txOutValid = txHeadValid && !txCtsHold; // RL14
	assign txSpace = QUEUE_FULL_COUNT - txCount; // RL21

	// ----------------------------------------------------------------
	// Modem inputs
	// ----------------------------------------------------------------
	logic [3:0] pinSync1_r;
	logic [3:0] pinSync2_r;
	logic [7:4] modemLevelNow;
	logic [3:0] delta_r;
	logic [3:0] deltaSet;
	logic modemStatusRead;
	logic [7:0] lineStatus;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pinSync1_r <= 4'hF;
			pinSync2_r <= 4'hF;
		end else begin
			pinSync1_r <= modemIn;
			pinSync2_r <= pinSync1_r;
		end
	end

	// Order: CTS, DSR, RI, CD
	always_comb begin
		if (modemControl_r[MC_LOOPBACK]) begin
			modemLevelNow = {modemControl_r[MC_OUT2], modemControl_r[MC_ALT_SELECT],
				modemControl_r[MC_DTR], modemControl_r[MC_RTS]}; // RL13
		end else begin
			modemLevelNow = ~{pinSync2_r[3], pinSync2_r[2], pinSync2_r[1], pinSync2_r[0]}; // RL13
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			modemLevel_r <= 4'h0;
		end else begin
			modemLevel_r <= modemLevelNow;
		end
	end

	assign deltaSet[0] = modemLevel_r[4] != modemLevelNow[4]; // RL11
	assign deltaSet[1] = modemLevel_r[5] != modemLevelNow[5]; // RL11
	assign deltaSet[2] = modemLevel_r[6] && !modemLevelNow[6]; // RL12
	assign deltaSet[3] = modemLevel_r[7] != modemLevelNow[7]; // RL11
	assign modemStatusRead = rdEn && regAddr == OFF_MODEM_STATUS && !altSelect;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : gDelta
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					delta_r[gi] <= 1'b0;
				end else if (deltaSet[gi]) begin
					delta_r[gi] <= 1'b1; // RL24
				end else if (modemStatusRead) begin
					delta_r[gi] <= 1'b0; // RL24
				end
			end
		end
	endgenerate

	assign modemStatusReq = modemIrqEnable && (delta_r != 4'h0); // RL11

	// ----------------------------------------------------------------
	// Flow control thresholds
	// ----------------------------------------------------------------
	logic [COUNT_W-1:0] haltLevel;
	logic [COUNT_W-1:0] resumeLevel;
	logic rtsAllowed_r;
	logic rtsN_r;
	logic xoffRequest_r;
	logic xonRequest_r;

	assign haltLevel = {1'b0, flowThreshold_r[3:0], 2'b00}; // RL17
	assign resumeLevel = {1'b0, flowThreshold_r[7:4], 2'b00}; // RL18

	// Halt wins if the two levels overlap
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rtsAllowed_r <= 1'b1;
		end else if (rxCount >= haltLevel) begin
			rtsAllowed_r <= 1'b0; // RL17
		end else if (rxCount <= resumeLevel) begin
			rtsAllowed_r <= 1'b1; // RL18
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			xoffRequest_r <= 1'b0;
			xonRequest_r <= 1'b0;
		end else begin
			xoffRequest_r <= swFlowEnable && rtsAllowed_r && rxCount >= haltLevel; // RL17
			xonRequest_r <= swFlowEnable && !rtsAllowed_r && rxCount < haltLevel && rxCount <= resumeLevel; // RL18
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rtsN_r <= 1'b1;
		end else if (modemControl_r[MC_LOOPBACK]) begin
			rtsN_r <= 1'b1;
		end else if (autoRtsEnable) begin
			rtsN_r <= !(modemControl_r[MC_RTS] && rtsAllowed_r); // RL17 RL18
		end else begin
			rtsN_r <= !modemControl_r[MC_RTS];
		end
	end

	assign rtsN = rtsN_r;
	assign dtrN = modemControl_r[MC_LOOPBACK] || !modemControl_r[MC_DTR];
	assign xoffRequest = xoffRequest_r;
	assign xonRequest = xonRequest_r;

	// ----------------------------------------------------------------
	// Trigger levels
	// ----------------------------------------------------------------
	logic [COUNT_W-1:0] txTrigLevel;
	logic [COUNT_W-1:0] rxTrigLevel;

	assign txTrigLevel = (triggerLevels_r[3:0] != 4'h0) ? {1'b0, triggerLevels_r[3:0], 2'b00}
		: LEGACY_TX_TRIG[legacyTxTrig]; // RL19
	assign rxTrigLevel = (triggerLevels_r[7:4] != 4'h0) ? {1'b0, triggerLevels_r[7:4], 2'b00}
		: LEGACY_RX_TRIG[legacyRxTrig]; // RL20
	assign txReadyReq = txSpace >= txTrigLevel; // RL19
	assign rxReadyReq = rxCount >= rxTrigLevel; // RL20

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	assign lineStatus = {
		errCount_r != '0, // RL10
		txCount == '0 && !txShiftBusy, // RL9
		txCount == '0, // RL8
		rxHeadValid && rxHead.breakSeen, // RL7
		rxHeadValid && rxHead.frameErr, // RL6
		rxHeadValid && rxHead.parityErr, // RL5
		overrun_r, // RL4
		rxHeadValid // RL3
	};

	always_comb begin
		regRData_nxt = 8'h00;
		case (regAddr)
			OFF_HOLDING: regRData_nxt = rxHeadValid ? rxHead.data : 8'h00;
			OFF_MODEM_CONTROL: regRData_nxt = modemControl_r;
			OFF_LINE_STATUS: regRData_nxt = lineStatus;
			OFF_MODEM_STATUS: regRData_nxt = altSelect ? flowThreshold_r : {modemLevel_r, delta_r}; // RL16
			OFF_SCRATCH: regRData_nxt = altSelect ? triggerLevels_r : scratchByte_r; // RL23
			OFF_TX_SPACE: regRData_nxt = {1'b0, txSpace}; // RL21
			OFF_RX_FILL: regRData_nxt = {1'b0, rxCount}; // RL21
			OFF_PIN_DIR: regRData_nxt = pinDirection_r;
			default: regRData_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			regRData_r <= 8'h00;
		end else if (rdEn) begin
			regRData_r <= regRData_nxt;
		end
	end

	assign regRData = regRData_r;
endmodule
`default_nettype wire

// [verif/modem_line_model.sv]
// Far side model: modem pins, received characters and a paced shifter
`timescale 1ns/1ps
`default_nettype none
module modem_line_model
	import uart_status_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Modem pins, active low
	output var modem_in_type modemIn,
	// Received characters
	output logic rxInValid,
	output var rx_entry_type rxIn,
	// Transmit shifter
	input wire logic txOutValid,
	input wire logic [7:0] txOutData,
	output logic txOutReady,
	output logic txShiftBusy
);
	int shiftLen = 2;
	logic [3:0] busyCnt = 4'h0;
	logic [7:0] sent[$];

	initial begin
		modemIn = 4'hF;
		rxInValid = 1'b0;
		rxIn = '0;
	end

	// Longer shiftLen stalls the transmit queue
	assign txShiftBusy = busyCnt != 4'h0;
	assign txOutReady = !txShiftBusy;
	always @(posedge ref_clk) begin
		if (txOutValid && txOutReady) begin
			sent.push_back(txOutData);
			busyCnt <= 4'(shiftLen);
		end else if (txShiftBusy) begin
			busyCnt <= busyCnt - 4'h1;
		end
	end

	// Data lines scrambled once the character is handed over
	task automatic send(input rx_entry_type e);
		rxIn <= e;
		rxInValid <= 1'b1;
		@(posedge ref_clk);
		rxInValid <= 1'b0;
		rxIn <= ~e;
		@(posedge ref_clk);
	endtask

	task automatic pins(input modem_in_type p);
		modemIn <= p;
		@(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// [verif/uart_status_core_assertions.sv]
// Concurrent checks on the ports of the status block
`timescale 1ns/1ps
`default_nettype none
module uart_status_core_assertions
	import uart_status_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWData,
	input wire logic [7:0] regRData,
	// Settings and status
	input wire logic enhancedEnable,
	input wire logic modemIrqEnable,
	input wire logic txShiftBusy,
	input wire logic txOutValid,
	input wire logic txOutReady,
	input wire logic xoffRequest,
	input wire logic xonRequest,
	input wire logic baudTick,
	input wire logic irEnable,
	input wire logic [7:0] pinDirection,
	input wire logic modemStatusReq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	logic wrOnly;
	logic lsRead;
	// A read wins over a simultaneous write
	assign wrOnly = regWrite && !regRead;
	assign lsRead = regRead && regAddr == OFF_LINE_STATUS;

	ir_write_gate_a: assert property (!$stable(irEnable) |-> $past(wrOnly && enhancedEnable && regAddr == OFF_MODEM_CONTROL))
		else $error("infrared enable moved without a permitted write");
	dir_load_a: assert property (wrOnly && regAddr == OFF_PIN_DIR |=> pinDirection == $past(regWData))
		else $error("pin direction did not take the written byte");
	dir_hold_a: assert property (!$stable(pinDirection) |-> $past(wrOnly && regAddr == OFF_PIN_DIR))
		else $error("pin direction changed without a write");
	baud_gap_a: assert property ($fell(baudTick) |-> ##[1:3] baudTick)
		else $error("baud tick gap longer than four cycles");
	irq_gate_a: assert property (!modemIrqEnable |-> !modemStatusReq)
		else $error("modem request while disabled");
	level_range_a: assert property (regRead && (regAddr == OFF_TX_SPACE || regAddr == OFF_RX_FILL) |=> regRData <= 8'h40)
		else $error("queue level above sixty-four");
	idle_empty_a: assert property (lsRead |=> regRData[5] || !regRData[6])
		else $error("idle reported with queue not empty");
	busy_idle_a: assert property (lsRead && txShiftBusy |=> !regRData[6])
		else $error("idle reported while shifting");
	error_summary_a: assert property (lsRead |=> regRData[7] || regRData[4:2] == 3'h0)
		else $error("head error without error summary");
	xoff_pulse_a: assert property (xoffRequest |=> !xoffRequest)
		else $error("halt request longer than one cycle");
	xon_pulse_a: assert property (xonRequest |=> !xonRequest)
		else $error("resume request longer than one cycle");

	status_read_c: cover property (lsRead);
	modem_req_c: cover property (modemStatusReq);
	halt_c: cover property (xoffRequest);
	pop_c: cover property (txOutValid && txOutReady);
endmodule

bind uart_status_core uart_status_core_assertions uart_status_core_assertions_inst (
	.ref_clk, .resetn, .regAddr, .regWrite, .regRead, .regWData, .regRData,
	.enhancedEnable, .modemIrqEnable, .txShiftBusy, .txOutValid, .txOutReady,
	.xoffRequest, .xonRequest, .baudTick, .irEnable, .pinDirection, .modemStatusReq
);
`default_nettype wire

// [verif/uart_status_core_bench.sv]
// Directed bench for the status, queue and modem block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module uart_status_core_bench;
	import uart_status_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regWData = 8'h00;
	logic enhancedEnable = 1'b0;
	logic autoCtsEnable = 1'b0;
	logic autoRtsEnable = 1'b0;
	logic swFlowEnable = 1'b0;
	logic modemIrqEnable = 1'b0;
	logic [1:0] legacyTxTrig = 2'h0;
	logic [1:0] legacyRxTrig = 2'h0;
	logic [7:0] regRData, txOutData, pinDirection, d;
	logic rxInValid, txOutValid, txOutReady, txShiftBusy, rtsN, dtrN, xoffRequest, xonRequest;
	logic baudTick, irEnable, modemStatusReq, txReadyReq, rxReadyReq;
	logic xoffSeen = 1'b0;
	logic xonSeen = 1'b0;
	rx_entry_type rxIn;
	modem_in_type modemIn;
	int mismatches = 0;
	int checks = 0;
	int ticks;
	int i;

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (xoffRequest) xoffSeen <= 1'b1;
		if (xonRequest) xonSeen <= 1'b1;
	end

	uart_status_core uart_status_core_inst (.ref_clk, .resetn, .regAddr, .regWrite, .regRead, .regWData,
		.regRData, .enhancedEnable, .autoCtsEnable, .autoRtsEnable, .swFlowEnable, .modemIrqEnable,
		.legacyTxTrig, .legacyRxTrig, .rxInValid, .rxIn, .txOutValid, .txOutReady, .txOutData,
		.txShiftBusy, .modemIn, .rtsN, .dtrN, .xoffRequest, .xonRequest, .baudTick, .irEnable,
		.pinDirection, .modemStatusReq, .txReadyReq, .rxReadyReq);
	modem_line_model modem_line_model_inst (.ref_clk, .modemIn, .rxInValid, .rxIn, .txOutValid,
		.txOutData, .txOutReady, .txShiftBusy);

	// Strobe lowered then one more edge, so calls never collide
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		regAddr <= a;
		regWData <= v;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		@(negedge ref_clk);
		@(negedge ref_clk);
		v = regRData;
		@(posedge ref_clk);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		rd(a, d);
		`CHK(d, e)
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic tk(output int n);
		n = 0;
		repeat (40) begin
			@(negedge ref_clk);
			n += int'(baudTick);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Whole run is near 1500 cycles
	initial begin
		#100us;
		mismatches++;
		wrap_up();
	end

	initial begin
		settle(4);
		resetn <= 1'b1;
		settle(1);
		rc(OFF_SCRATCH, 8'hFF);
		rc(OFF_TX_SPACE, 8'h40);
		rc(OFF_RX_FILL, 8'h00);
		rc(OFF_LINE_STATUS, 8'h60);
		rc(OFF_PIN_DIR, 8'h00);
		rc(4'hB, 8'h00);
		wr(OFF_SCRATCH, 8'h5A);
		rc(OFF_SCRATCH, 8'h5A);
		wr(OFF_PIN_DIR, 8'hA5);
		`CHK(pinDirection, 8'hA5)
		rc(OFF_PIN_DIR, 8'hA5);
		// Upper control bits locked while enhanced is off
		wr(OFF_MODEM_CONTROL, 8'hC0);
		tk(ticks);
		`CHK(ticks, 40)
		`CHK(irEnable, 1'b0)
		enhancedEnable <= 1'b1;
		wr(OFF_MODEM_CONTROL, 8'hC0);
		tk(ticks);
		`CHK(ticks, 10)
		`CHK(irEnable, 1'b1)
		wr(OFF_MODEM_CONTROL, 8'h06);
		rc(OFF_SCRATCH, 8'h00);
		wr(OFF_MODEM_STATUS, 8'h48);
		rc(OFF_MODEM_STATUS, 8'h48);
		wr(OFF_SCRATCH, 8'h10);
		rc(OFF_SCRATCH, 8'h10);
		enhancedEnable <= 1'b0;
		rc(OFF_SCRATCH, 8'h5A);
		enhancedEnable <= 1'b1;
		// Transmit held by CTS, then released into a slow shifter
		autoCtsEnable <= 1'b1;
		modem_line_model_inst.shiftLen = 6;
		for (i = 0; i < 3; i++) wr(OFF_HOLDING, 8'(8'h11 * (i + 1)));
		rc(OFF_TX_SPACE, 8'h3D);
		rc(OFF_LINE_STATUS, 8'h00);
		`CHK(txOutValid, 1'b0)
		modem_line_model_inst.pins(4'hE);
		settle(60);
		`CHK(modem_line_model_inst.sent.size(), 3)
		`CHK(modem_line_model_inst.sent[2], 8'h33)
		rc(OFF_LINE_STATUS, 8'h60);
		modem_line_model_inst.pins(4'hF);
		settle(6);
		for (i = 0; i < 65; i++) wr(OFF_HOLDING, 8'(i));
		rc(OFF_TX_SPACE, 8'h00);
		`CHK(txReadyReq, 1'b0)
		modem_line_model_inst.pins(4'hE);
		settle(600);
		`CHK(modem_line_model_inst.sent.size(), 67)
		`CHK(modem_line_model_inst.sent[66], 8'h3F)
		`CHK(txReadyReq, 1'b1)
		autoCtsEnable <= 1'b0;
		// Receive path: error tags, break, overrun and flow levels
		autoRtsEnable <= 1'b1;
		swFlowEnable <= 1'b1;
		modem_line_model_inst.send({3'b000, 8'h41});
		modem_line_model_inst.send({3'b001, 8'h42});
		rc(OFF_LINE_STATUS, 8'hE1);
		rc(OFF_HOLDING, 8'h41);
		rc(OFF_LINE_STATUS, 8'hE5);
		rc(OFF_HOLDING, 8'h42);
		rc(OFF_LINE_STATUS, 8'h60);
		modem_line_model_inst.send({3'b010, 8'h43});
		rc(OFF_LINE_STATUS, 8'hE9);
		rc(OFF_HOLDING, 8'h43);
		modem_line_model_inst.send({3'b100, 8'h00});
		modem_line_model_inst.send({3'b100, 8'h00});
		rc(OFF_RX_FILL, 8'h01);
		rc(OFF_LINE_STATUS, 8'hF1);
		rc(OFF_HOLDING, 8'h00);
		for (i = 0; i < 64; i++) begin
			modem_line_model_inst.send({3'b000, 8'(i)});
			settle(2);
			if (i == 2) `CHK(rxReadyReq, 1'b0)
			if (i == 3) `CHK(rxReadyReq, 1'b1)
			if (i == 31) `CHK(rtsN, 1'b1)
		end
		rc(OFF_RX_FILL, 8'h40);
		modem_line_model_inst.send({3'b000, 8'hFF});
		rc(OFF_LINE_STATUS, 8'h63);
		rc(OFF_LINE_STATUS, 8'h61);
		`CHK(xoffSeen, 1'b1)
		legacyRxTrig <= 2'h3;
		wr(OFF_SCRATCH, 8'h00);
		for (i = 0; i < 64; i++) begin
			rd(OFF_HOLDING, d);
			`CHK(d, 8'(i))
			if (i == 3) `CHK(rxReadyReq, 1'b1)
			if (i == 4) `CHK(rxReadyReq, 1'b0)
		end
		rc(OFF_RX_FILL, 8'h00);
		`CHK(rtsN, 1'b0)
		`CHK(xonSeen, 1'b1)
		rc(OFF_LINE_STATUS, 8'h60);
		// Modem inputs, deltas and loopback
		enhancedEnable <= 1'b0;
		modemIrqEnable <= 1'b1;
		rd(OFF_MODEM_STATUS, d);
		modem_line_model_inst.pins(4'h0);
		settle(6);
		`CHK(modemStatusReq, 1'b1)
		rc(OFF_MODEM_STATUS, 8'hFA);
		rc(OFF_MODEM_STATUS, 8'hF0);
		`CHK(modemStatusReq, 1'b0)
		modem_line_model_inst.pins(4'hF);
		settle(6);
		rc(OFF_MODEM_STATUS, 8'h0F);
		wr(OFF_MODEM_CONTROL, 8'h1B);
		settle(4);
		rd(OFF_MODEM_STATUS, d);
		`CHK(d[7:4], 4'hB)
		`CHK(rtsN, 1'b1)
		`CHK(dtrN, 1'b1)
		wrap_up();
	end
endmodule
`default_nettype wire
